// File: hdl/emb_regs.svh
/*
  Register offsets, field positions, reset values and sizes of the
  embedded memory block.
  Assumes inclusion by bare name from the package and the block files.
*/
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ---------------------------------------------------------------
`define EMB_ADDR_CFG 4'h0
`define EMB_ADDR_LDADDR 4'h4
`define EMB_ADDR_LDDATA 4'h8
`define EMB_ADDR_STAT 4'hC

// ---------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------
`define EMB_CFG_W 17
`define EMB_CFG_RST 17'h00000
`define EMB_LDADDR_RST 11'h000
`define EMB_STAT_EMPTY 0
`define EMB_STAT_FULL 1
`define EMB_STAT_CNT_LSB 2

// ---------------------------------------------------------------
// storage geometry: 256 rows of 8 bits, 2048 bits in all
// ---------------------------------------------------------------
`define EMB_BITS 2048
`define EMB_ROWS 256
`define EMB_DEPTH_MIN 12'h100

`endif

// File: hdl/emb_pkg.sv
/*
  Types and shared helper functions of the embedded memory block.
  Assumes emb_regs.svh is on the include path.
*/
`default_nettype none
`include "emb_regs.svh"

package emb_pkg;

  typedef enum logic [2:0] {
    mode_spram, mode_rom, mode_dpram, mode_fifo, mode_lut
  } emb_mode_t;

  typedef enum logic [1:0] {
    csel_global, csel_pin, csel_local, csel_spare
  } emb_csel_t;

  // width: 0 = 256x8, 1 = 512x4, 2 = 1024x2, 3 = 2048x1
  typedef struct packed {
    logic [2:0] blk_id;
    logic casc_en;
    logic we_local;
    emb_csel_t oclk_sel;
    emb_csel_t iclk_sel;
    logic reg_dout;
    logic reg_addr;
    logic reg_din;
    logic [1:0] width;
    emb_mode_t mode;
  } emb_cfg_t;

  typedef struct packed {
    logic [2:0] blk;
    logic [10:0] addr;
    logic [10:0] raddr;
    logic [7:0] wdata;
    logic we;
    logic push;
    logic pop;
  } emb_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } emb_bus_t;

  function automatic logic [7:0] emb_row(input logic [10:0] a,
                                         input logic [1:0] w);
    emb_row = 8'(a >> w);
  endfunction

  function automatic logic [2:0] emb_shift(input logic [10:0] a,
                                           input logic [1:0] w);
    case (w)
      2'h0: emb_shift = 3'h0;
      2'h1: emb_shift = {a[0], 2'h0};
      2'h2: emb_shift = {a[1:0], 1'h0};
      default: emb_shift = a[2:0];
    endcase
  endfunction

  function automatic logic [7:0] emb_mask(input logic [1:0] w);
    case (w)
      2'h0: emb_mask = 8'hFF;
      2'h1: emb_mask = 8'h0F;
      2'h2: emb_mask = 8'h03;
      default: emb_mask = 8'h01;
    endcase
  endfunction

  function automatic logic [11:0] emb_depth(input logic [1:0] w);
    emb_depth = 12'(`EMB_DEPTH_MIN << w);
  endfunction

endpackage

`default_nettype wire

// File: hdl/emb_storage.sv
/*
  The 2048-bit array of the embedded memory block, one write port and
  one combinational read port, both word addressed at the chosen width.
  Assumes the caller gives at most one write strobe per clock.
*/
`default_nettype none
`include "emb_regs.svh"

module emb_storage
  import emb_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] width,
  input wire logic we,
  input wire logic [10:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [10:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:`EMB_ROWS-1];
  logic [7:0] wmask;
  logic [7:0] wrow_new;
  logic [7:0] wrow;

  // ---------------------------------------------------------------
  // write: read-modify-write of one row, lane picked by the address
  // ---------------------------------------------------------------
  always_comb
  begin
    wrow = emb_row(waddr, width);
    wmask = 8'(emb_mask(width) << emb_shift(waddr, width));
    wrow_new = (mem[wrow] & ~wmask)
             | (8'((wdata & emb_mask(width)) << emb_shift(waddr, width)));
  end

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[wrow] <= wrow_new;
    end
  end

  // ---------------------------------------------------------------
  // read: narrow words sit in the low bits, upper bits zero
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata = 8'(mem[emb_row(raddr, width)] >> emb_shift(raddr, width))
          & emb_mask(width);
  end

endmodule

`default_nettype wire

// File: hdl/emb_memory_block.sv
/*
  Embedded memory block: 2048-bit store usable as single-port RAM, ROM,
  dual-port RAM, FIFO or lookup table, with optional input, address and
  output registers, selectable input and output clock enables, and a
  plain register port for configuration and pattern loading.
  Assumes one clock; user logic and the register master sit on it, the
  dedicated clock pin does not and is synchronised here.
*/
`default_nettype none
`include "emb_regs.svh"

// Summary of operation
// - The block holds 2048 bits, all usable in every organisation.
// - It acts as single-port RAM, ROM, dual-port RAM or FIFO storage.
// - RAM use offers 256x8, 512x4, 1024x2 or 2048x1 words.
// - Wider memories use several blocks side by side on shared inputs.
// - Blocks cascade in depth by block select with unchanged timing.
// - Registers exist on input and output so storage can be synchronous.
// - The write strobe is made inside, timed from the clock.
// - Input and output sides take independently chosen clocks.
// - Data in, data out and address with write enable register apart.
// - Write enable comes from a global signal or from user logic.
// - Each side's clock is global, a dedicated pin or user logic.
// - Logic mode returns a preloaded word for each input pattern.
module emb_memory_block
  import emb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire emb_pkg::emb_bus_t bus,
  output logic [31:0] bus_rdata,
  input wire emb_pkg::emb_req_t req,
  input wire logic global_we,
  input wire logic global_en,
  input wire logic local_in_en,
  input wire logic local_out_en,
  input wire logic clk_pin,
  output logic [7:0] rdata,
  output logic fifo_full,
  output logic fifo_empty
);
  import emb_pkg::*;

  emb_cfg_t cfg_q, cfg_d;
  logic [10:0] ld_addr_q, ld_addr_d;
  logic [31:0] bus_rdata_q, bus_rdata_d;
  logic ld_we;
  logic cfg_wr;

  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic pin_tick;
  logic in_tick, out_tick;

  logic [7:0] din_q, din_d;
  logic [10:0] addr_q, addr_d;
  logic [10:0] raddr_q, raddr_d;
  logic [2:0] blk_q, blk_d;
  logic wr_pend_q, wr_pend_d;

  logic live_we, live_sel, sel_eff, writable, ram_strobe;
  logic [10:0] waddr_eff, raddr_eff;
  logic [7:0] wdata_eff;

  logic [10:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] depth_d;
  logic push_ok, pop_ok;
  logic full_q, full_d, empty_q, empty_d;

  logic st_we;
  logic [10:0] st_waddr;
  logic [7:0] st_wdata, st_rdata, rd_word;
  logic [7:0] pipe_q, pipe_d, rdata_q, rdata_d;

  function automatic logic pick_tick(input emb_csel_t s, input logic g,
                                     input logic p, input logic l);
    case (s)
      csel_pin: pick_tick = p;
      csel_local: pick_tick = l;
      default: pick_tick = g;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_comb
  begin
    cfg_d = cfg_q;
    ld_addr_d = ld_addr_q;
    ld_we = 1'b0;
    cfg_wr = 1'b0;
    bus_rdata_d = 32'h0000_0000;
    if (bus.wr)
    begin
      case (bus.addr)
        `EMB_ADDR_CFG:
        begin
          cfg_d = emb_cfg_t'(bus.wdata[`EMB_CFG_W-1:0]);
          cfg_wr = 1'b1;
        end
        `EMB_ADDR_LDADDR: ld_addr_d = bus.wdata[10:0];
        `EMB_ADDR_LDDATA:
        begin
          // pattern load, address steps so a table streams in
          ld_we = 1'b1;
          ld_addr_d = ld_addr_q + 11'h001;
        end
        default: ;
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        `EMB_ADDR_CFG: bus_rdata_d = {15'h0000, cfg_q};
        `EMB_ADDR_LDADDR: bus_rdata_d = {21'h000000, ld_addr_q};
        `EMB_ADDR_STAT:
        begin
          bus_rdata_d[`EMB_STAT_EMPTY] = empty_q;
          bus_rdata_d[`EMB_STAT_FULL] = full_q;
          bus_rdata_d[`EMB_STAT_CNT_LSB +: 12] = cnt_q;
        end
        default: bus_rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q <= emb_cfg_t'(`EMB_CFG_RST);
      ld_addr_q <= `EMB_LDADDR_RST;
      bus_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_q <= cfg_d;
      ld_addr_q <= ld_addr_d;
      bus_rdata_q <= bus_rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // clock selection per side
  // ---------------------------------------------------------------
  // the pin is slow and foreign; its rising edge becomes an enable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= clk_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_comb
  begin
    pin_tick = pin_s2_q & ~pin_s3_q;
    in_tick = pick_tick(cfg_q.iclk_sel, global_en, pin_tick,
                        local_in_en);
    out_tick = pick_tick(cfg_q.oclk_sel, global_en, pin_tick,
                         local_out_en);
  end

  // ---------------------------------------------------------------
  // input registers and internal write strobe
  // ---------------------------------------------------------------
  always_comb
  begin
    live_we = cfg_q.we_local ? req.we : global_we;
    live_sel = ~cfg_q.casc_en | (req.blk == cfg_q.blk_id);
    din_d = in_tick ? req.wdata : din_q;
    addr_d = in_tick ? req.addr : addr_q;
    raddr_d = in_tick ? req.raddr : raddr_q;
    blk_d = in_tick ? req.blk : blk_q;
    // pending for one cycle only: the write lands right after sampling
    wr_pend_d = in_tick & live_we & live_sel;
    wdata_eff = cfg_q.reg_din ? din_q : req.wdata;
    waddr_eff = cfg_q.reg_addr ? addr_q : req.addr;
    sel_eff = cfg_q.reg_addr ? (~cfg_q.casc_en | (blk_q == cfg_q.blk_id))
                             : live_sel;
    writable = (cfg_q.mode == mode_spram) || (cfg_q.mode == mode_dpram);
    // no external strobe timing: one clock-aligned pulse per write
    ram_strobe = writable & (cfg_q.reg_addr ? wr_pend_q
                 : (in_tick & live_we & live_sel));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      din_q <= 8'h00;
      addr_q <= 11'h000;
      raddr_q <= 11'h000;
      blk_q <= 3'h0;
      wr_pend_q <= 1'b0;
    end
    else
    begin
      din_q <= din_d;
      addr_q <= addr_d;
      raddr_q <= raddr_d;
      blk_q <= blk_d;
      wr_pend_q <= wr_pend_d;
    end
  end

  // ---------------------------------------------------------------
  // fifo pointers
  // ---------------------------------------------------------------
  always_comb
  begin
    push_ok = (cfg_q.mode == mode_fifo) & in_tick & req.push & ~full_q;
    pop_ok = (cfg_q.mode == mode_fifo) & out_tick & req.pop & ~empty_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (push_ok)
    begin
      wr_ptr_d = (wr_ptr_q + 11'h001) & 11'(emb_depth(cfg_q.width) - 12'h001);
    end
    if (pop_ok)
    begin
      rd_ptr_d = (rd_ptr_q + 11'h001) & 11'(emb_depth(cfg_q.width) - 12'h001);
    end
    if (push_ok && !pop_ok)
    begin
      cnt_d = cnt_q + 12'h001;
    end
    else if (pop_ok && !push_ok)
    begin
      cnt_d = cnt_q - 12'h001;
    end
    // reshaping the block empties the fifo
    if (cfg_wr)
    begin
      wr_ptr_d = 11'h000;
      rd_ptr_d = 11'h000;
      cnt_d = 12'h000;
    end
    depth_d = emb_depth(cfg_d.width);
    full_d = (cnt_d == depth_d);
    empty_d = (cnt_d == 12'h000);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= 11'h000;
      rd_ptr_q <= 11'h000;
      cnt_q <= 12'h000;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  // ---------------------------------------------------------------
  // storage and its port steering
  // ---------------------------------------------------------------
  always_comb
  begin
    // a pattern load takes the port; loads are meant for idle time
    if (ld_we)
    begin
      st_we = 1'b1;
      st_waddr = ld_addr_q;
      st_wdata = bus.wdata[7:0];
    end
    else if (cfg_q.mode == mode_fifo)
    begin
      st_we = push_ok;
      st_waddr = wr_ptr_q;
      st_wdata = req.wdata;
    end
    else
    begin
      st_we = ram_strobe;
      st_waddr = waddr_eff;
      st_wdata = wdata_eff;
    end
    case (cfg_q.mode)
      mode_fifo: raddr_eff = rd_ptr_q;
      mode_dpram: raddr_eff = cfg_q.reg_addr ? raddr_q : req.raddr;
      default: raddr_eff = waddr_eff;
    endcase
  end

  emb_storage u_storage (
    .clk(clk),
    .width(cfg_q.width),
    .we(st_we),
    .waddr(st_waddr),
    .wdata(st_wdata),
    .raddr(raddr_eff),
    .rdata(st_rdata)
  );

  // ---------------------------------------------------------------
  // output path
  // ---------------------------------------------------------------
  always_comb
  begin
    // deselected blocks outside fifo mode give zero so cascaded outputs can be or-ed
    rd_word = ((cfg_q.mode == mode_fifo) || sel_eff) ? st_rdata
                                                     : 8'h00;
    pipe_d = out_tick ? rd_word : pipe_q;
    rdata_d = rdata_q;
    if (out_tick)
    begin
      rdata_d = cfg_q.reg_dout ? pipe_q : rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pipe_q <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      pipe_q <= pipe_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // several blocks side by side share req and concatenate rdata
  assign rdata = rdata_q;
  assign bus_rdata = bus_rdata_q;
  assign fifo_full = full_q;
  assign fifo_empty = empty_q;

endmodule

`default_nettype wire

// File: tb/emb_user.sv
/*
  User logic on the far side of the memory block: requests, write
  enables and the local clock enables of both sides.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`default_nettype none
module emb_user
  import emb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  output emb_pkg::emb_req_t req,
  output logic global_we,
  output logic local_in_en,
  output logic local_out_en
);
  import emb_pkg::*;
  logic ph_q;
  logic ph_d;
  // -------------------------------------
  // local enables, every other cycle when slow
  // -------------------------------------
  always_comb ph_d = slow ? ~ph_q : 1'b1;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      ph_q <= 1'b0;
    else
      ph_q <= ph_d;
  assign local_in_en = ph_q;
  assign local_out_en = ph_q;
  initial
  begin
    req = '0;
    global_we = 1'b0;
  end
  // held over two edges when slow so one ticking edge falls inside
  task automatic put(input logic [2:0] b, input logic [10:0] a,
    input logic [10:0] r, input logic [7:0] d, input logic [1:0] w);
    req.blk <= b;
    req.addr <= a;
    req.raddr <= r;
    req.wdata <= d;
    req.we <= w[1];
    global_we <= w[0];
    repeat (slow ? 2 : 1) @(posedge clk);
  endtask
  task automatic fifo(input logic pu, input logic po, input logic [7:0] d);
    req.push <= pu;
    req.pop <= po;
    req.wdata <= d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/emb_monitor.sv
/*
  Port checker of the memory block: register port and fifo flags.
  Assumes emb_pkg is compiled first; bound below.
*/
`default_nettype none
module emb_monitor
  import emb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire emb_pkg::emb_bus_t bus,
  input wire logic [31:0] bus_rdata,
  input wire logic fifo_full,
  input wire logic fifo_empty
);
  import emb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // -------------------------------------
  // properties
  // -------------------------------------
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> bus_rdata == 32'h0) else $error("stray rdata");
  a_stat_flags: assert property (
    $past(bus.rd) && $past(bus.addr) == 4'hC |-> bus_rdata[31:14] == 18'h0
    && bus_rdata[1:0] == {$past(fifo_full), $past(fifo_empty)})
    else $error("status flags");
  a_stat_count: assert property (
    $past(bus.rd) && $past(bus.addr) == 4'hC |->
    bus_rdata[0] == (bus_rdata[13:2] == 12'h0)) else $error("count");
  a_lddata_wo: assert property (
    $past(bus.rd) && $past(bus.addr) == 4'h8 |-> bus_rdata == 32'h0)
    else $error("load data read");
  a_unmapped_zero: assert property (
    $past(bus.rd) && $past(bus.addr[1:0]) != 2'h0 |-> bus_rdata == 32'h0)
    else $error("unmapped read");
  a_cfg_readback: assert property (
    bus.wr && bus.addr == 4'h0 ##1 bus.rd && bus.addr == 4'h0 |=>
    bus_rdata == {15'h0, $past(bus.wdata[16:0], 2)}) else $error("cfg");
  a_ldaddr_back: assert property (
    bus.wr && bus.addr == 4'h4 ##1 bus.rd && bus.addr == 4'h4 |=>
    bus_rdata == {21'h0, $past(bus.wdata[10:0], 2)}) else $error("ldaddr");
  a_cfg_flush: assert property (
    bus.wr && bus.addr == 4'h0 |=> fifo_empty && !fifo_full)
    else $error("fifo not flushed");
  a_flag_excl: assert property (
    !(fifo_full && fifo_empty)) else $error("full and empty");
  c_full: cover property ($rose(fifo_full));
  c_drain: cover property ($fell(fifo_empty) ##[1:600] $rose(fifo_empty));
  c_stat: cover property ($past(bus.rd) && $past(bus.addr) == 4'hC);
endmodule
bind emb_memory_block emb_monitor u_emb_monitor (
  .clk(clk),
  .rst_b(rst_b),
  .bus(bus),
  .bus_rdata(bus_rdata),
  .fifo_full(fifo_full),
  .fifo_empty(fifo_empty)
);
`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench of the memory block.
  Assumes emb_user as user logic and emb_monitor bound to the block.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import emb_pkg::*;
  logic clk, rst_b, global_en, clk_pin, slow, due_u, rd_p, due_f;
  logic global_we, l_in, l_out, fifo_full, fifo_empty;
  emb_bus_t bus;
  emb_req_t req;
  logic [31:0] bus_rdata, seed, got;
  logic [31:0] exp_q[$];
  logic [7:0] fq[$];
  logic [7:0] rdata, mk, v1, v2;
  logic [10:0] wa [4];
  logic [7:0] wd [4];
  logic [11:0] dp;
  int err_count, num_checks, cyc;
  emb_memory_block u_emb_memory_block (.clk(clk), .rst_b(rst_b),
    .bus(bus), .bus_rdata(bus_rdata), .req(req), .global_we(global_we),
    .global_en(global_en), .local_in_en(l_in), .local_out_en(l_out),
    .clk_pin(clk_pin), .rdata(rdata), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty));
  emb_user u_emb_user (.clk(clk), .rst_b(rst_b), .slow(slow), .req(req),
    .global_we(global_we), .local_in_en(l_in), .local_out_en(l_out));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // -------------------------------------
  // tasks
  // -------------------------------------
  function automatic logic [31:0] nx();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // strobes are left up; bi() drops them one edge later
  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic br(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
  endtask
  task automatic bi();
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [31:0] d);
    bw(4'h0, d);
    bi();
  endtask
  task automatic chk(input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    due_u <= 1'b1;
    @(posedge clk);
    due_u <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chf(input logic [1:0] e);
    exp_q.push_back({30'h0, e});
    due_f <= 1'b1;
    @(posedge clk);
    due_f <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ur(input logic [2:0] b, input logic [10:0] a, input int lat,
    input logic [7:0] e);
    u_emb_user.put(b, a, a, 8'h0, 2'b00);
    repeat (lat - 1) @(posedge clk);
    chk(e);
  endtask
  always @(posedge clk)
  begin
    if (rd_p || due_u || due_f)
    begin
      got = rd_p ? bus_rdata
          : due_f ? {30'h0, fifo_full, fifo_empty} : {24'h0, rdata};
      num_checks++;
      if (exp_q.size() == 0 || got !== exp_q[0])
      begin
        $display("ERROR %0t got %h exp %h", $time, got, exp_q[0]);
        err_count++;
      end
      void'(exp_q.pop_front());
    end
    rd_p = bus.rd;
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    global_en = 1'b1;
    clk_pin = 1'b0;
    slow = 1'b0;
    due_u = 1'b0;
    due_f = 1'b0;
    rd_p = 1'b0;
    bus = '0;
    seed = 32'h4EC0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    br(4'h0, 32'h0);
    br(4'hC, 32'h1);
    br(4'h2, 32'h0);
    bw(4'h4, 32'h7FF);
    br(4'h4, 32'h7FF);
    bw(4'h8, 32'h5A);
    br(4'h4, 32'h0);
    bi();
    $display("registers done");
    for (int w = 0; w < 4; w++)
    begin
      cfg(32'(w) << 3);
      dp = 12'h100 << w;
      mk = 8'((9'h1 << (8 >> w)) - 9'h1);
      for (int k = 0; k < 4; k++)
      begin
        wa[k] = k == 3 ? 11'(dp - 12'h1) : 11'(k * dp / 4 + nx() % (dp / 4));
        wd[k] = 8'(nx()) & mk;
        u_emb_user.put(3'h0, wa[k], wa[k], wd[k], 2'b01);
      end
      for (int k = 0; k < 4; k++)
        ur(3'h0, wa[k], 1, wd[k]);
    end
    $display("widths done");
    cfg(32'h1);
    bw(4'h4, 32'hFC);
    for (int i = 252; i < 256; i++)
      bw(4'h8, 32'((i >> 4) * (i & 15)));
    bi();
    for (int m = 1; m < 5; m += 3)
    begin
      cfg(32'(m));
      u_emb_user.put(3'h0, 11'hFD, 11'hFD, 8'h0, 2'b01);
      for (int i = 252; i < 256; i++)
        ur(3'h0, 11'(i), 1, 8'((i >> 4) * (i & 15)));
    end
    $display("rom and lut done");
    cfg(32'h160E0);
    v1 = 8'(nx());
    u_emb_user.put(3'h5, 11'h10, 11'h10, v1, 2'b01);
    u_emb_user.put(3'h3, 11'h10, 11'h10, ~v1, 2'b01);
    ur(3'h5, 11'h10, 3, v1);
    ur(3'h3, 11'h10, 3, 8'h0);
    cfg(32'h2);
    v2 = 8'(nx());
    u_emb_user.put(3'h0, 11'h30, 11'h30, v1, 2'b01);
    u_emb_user.put(3'h0, 11'h31, 11'h30, v2, 2'b01);
    chk(v1);
    ur(3'h0, 11'h31, 1, v2);
    $display("registered, cascade, dual port done");
    slow <= 1'b1;
    cfg(32'h1A00);
    v1 = 8'(nx());
    u_emb_user.put(3'h0, 11'h40, 11'h40, v1, 2'b10);
    u_emb_user.put(3'h0, 11'h31, 11'h31, ~v2, 2'b01);
    ur(3'h0, 11'h40, 1, v1);
    ur(3'h0, 11'h31, 1, v2);
    slow <= 1'b0;
    cfg(32'h400);
    u_emb_user.put(3'h0, 11'h40, 11'h40, 8'h0, 2'b00);
    repeat (5) @(posedge clk);
    chk(v2);
    clk_pin <= 1'b1;
    repeat (2) @(posedge clk);
    clk_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk(v1);
    $display("clock sources done");
    cfg(32'h3);
    for (int i = 0; i < 3; i++)
      u_emb_user.fifo(1'b1, 1'b0, 8'(i));
    u_emb_user.fifo(1'b0, 1'b0, 8'h0);
    br(4'hC, 32'hC);
    cfg(32'h3);
    br(4'hC, 32'h1);
    bi();
    for (int i = 0; i < 257; i++)
    begin
      v1 = 8'(nx());
      if (i < 256)
        fq.push_back(v1);
      u_emb_user.fifo(1'b1, 1'b0, v1);
    end
    u_emb_user.fifo(1'b0, 1'b0, 8'h0);
    br(4'hC, 32'h402);
    bi();
    chf(2'h2);
    while (fq.size() > 0)
    begin
      chk(fq.pop_front());
      u_emb_user.fifo(1'b0, 1'b1, 8'h0);
      u_emb_user.fifo(1'b0, 1'b0, 8'h0);
    end
    u_emb_user.fifo(1'b0, 1'b1, 8'h0);
    u_emb_user.fifo(1'b0, 1'b0, 8'h0);
    br(4'hC, 32'h1);
    bi();
    chf(2'h1);
    $display("fifo done");
    final_report();
  end
endmodule
`default_nettype wire
